// ==== rpo_defs.svh ====
// Constants for the reset pad sequencer and option decoder
`ifndef RPO_DEFS_SVH
`define RPO_DEFS_SVH

// ----------------------------------------------------------------
// Option word field positions and factory defaults
// ----------------------------------------------------------------
`define RPO_OPT_SUPPLY_BIT   0
`define RPO_OPT_OSCMARG_BIT  1
`define RPO_OPT_WDOG_BIT     2
`define RPO_OPT_WIDTH        3
`define RPO_OPT_DEFAULT      3'h7

// ----------------------------------------------------------------
// Timing: RC oscillator cycles
// ----------------------------------------------------------------
`define RPO_RST_HOLD_CYC     40
`define RPO_PH3_MIN_CYC      40
`define RPO_CNT_WIDTH        6

// ----------------------------------------------------------------
// Trace pad count
// ----------------------------------------------------------------
`define RPO_TRACE_DATA_W     4

`endif

// ==== rpo_pkg.sv ====
// Types for the reset pad sequencer and option decoder
package rpo_pkg;

  typedef enum logic [2:0] {
    RPO_POWERUP = 3'b000,
    RPO_PHASE1  = 3'b001,
    RPO_PHASE2  = 3'b010,
    RPO_PHASE3  = 3'b011,
    RPO_RUN     = 3'b100
  } rpo_phase_e;

  typedef struct packed {
    logic supply_level_select;
    logic osc_high_margin;
    logic watchdog_enable;
  } rpo_opt_s;

endpackage

// ==== rpo_opt_if.sv ====
// Option load handshake between sequencer and option loader
interface rpo_opt_if;
  logic       load_start;
  logic       load_done;
  logic [2:0] opt_word;

  modport seq (output load_start, input load_done, input opt_word);
  modport ldr (input load_start, output load_done, output opt_word);
endinterface

// ==== rpo_opt_loader.sv ====
// Captures the user option word from nonvolatile shadow memory
`include "rpo_defs.svh"

module rpo_opt_loader (
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  input  wire logic                     nvm_valid,
  input  wire logic [`RPO_OPT_WIDTH-1:0] user_option_word,
  rpo_opt_if.ldr                        opt
);

  logic                      done_q;
  logic [`RPO_OPT_WIDTH-1:0] word_q;

  // ----------------------------------------------------------------
  // Capture once per reset, defaults kept until then
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      done_q <= 1'b0;
      word_q <= `RPO_OPT_DEFAULT; // [RULE_12]
    end else if (opt.load_start && !done_q && nvm_valid) begin
      done_q <= 1'b1;
      word_q <= user_option_word; // [RULE_12]
    end
  end

  assign opt.load_done = done_q;
  assign opt.opt_word  = word_q;

  chk_default_held: assert property ( // [RULE_12]
    @(posedge ref_clk) disable iff (!reset_n)
    !done_q |-> word_q == `RPO_OPT_DEFAULT)
    else $error("option word changed before load");

endmodule

// ==== rpo_reset_pads.sv ====
// Reset phase pad controller and user option decoder
//
// Function
// [RULE_01] Under reset every pad takes a fixed setup that software cannot alter.
// [RULE_02] In the power-up phase every pad driver is high impedance.
// [RULE_03] After power-up all pads stay high impedance except the listed ones.
// [RULE_04] The boot-select pad is pulled down so fetch starts from flash.
// [RULE_05] Out of reset the listed port pads are inputs with weak pull-ups.
// [RULE_06] The reset pad is driven low until 40 RC cycles after phase two ends.
// [RULE_07] Phase three lasts at least 40 RC cycles.
// [RULE_08] Under reset the trace and event pads are forced to output; the code leaves them high impedance in the power-up phase.
// [RULE_09] Supply option 0 means a 5.0 V supply and 1 means 3.3 V.
// [RULE_10] Oscillator option 0 is low consumption and 1 is high margin.
// [RULE_11] Watchdog option 0 leaves the watchdog off after reset.
// [RULE_12] Each option bit defaults to 1 and the programmed value is honoured.
// [RULE_13] Watchdog option 1 starts the watchdog enabled after reset.
// [RULE_14] Options are loaded during reset before the reset pad is released.
`include "rpo_defs.svh"

module rpo_reset_pads #(
  parameter int HOLD_CYC  = `RPO_RST_HOLD_CYC,
  parameter int PH3_CYC   = `RPO_PH3_MIN_CYC,
  parameter int TRACE_W   = `RPO_TRACE_DATA_W
) (
  input  wire logic                      ref_clk,
  input  wire logic                      reset_n,
  input  wire logic                      fast_internal_rc_osc,
  input  wire logic                      power_up_done,
  input  wire logic                      phase1_done,
  input  wire logic                      phase2_done,
  input  wire logic                      nvm_valid,
  input  wire logic [`RPO_OPT_WIDTH-1:0] user_option_word,
  input  wire logic                      sw_pad_override,
  output logic                           reset_pad_out,
  output logic                           reset_pad_oe_n,
  output logic                           boot_source_select_pad_pd,
  output logic                           pullup_pads_wpu,
  output logic                           pullup_pads_ibe,
  output logic                           all_pads_hiz,
  output logic [TRACE_W-1:0]             trace_data_out_oe_n,
  output logic                           trace_clock_out_oe_n,
  output logic                           debug_event_out_oe_n,
  output logic                           trace_msg_start_end_oe_n,
  output logic                           supply_level_select,
  output logic                           osc_high_margin,
  output logic                           watchdog_enable,
  output rpo_pkg::rpo_phase_e            phase,
  output logic                           core_run
);
  import rpo_pkg::*;

  localparam logic [`RPO_CNT_WIDTH-1:0] HOLD_LAST =
    `RPO_CNT_WIDTH'(HOLD_CYC - 1);
  localparam logic [`RPO_CNT_WIDTH-1:0] PH3_LAST =
    `RPO_CNT_WIDTH'(PH3_CYC - 1);

  rpo_opt_if opt_if ();

  rpo_opt_loader u_loader (
    .ref_clk          (ref_clk),
    .reset_n          (reset_n),
    .nvm_valid        (nvm_valid),
    .user_option_word (user_option_word),
    .opt              (opt_if.ldr)
  );

  // ----------------------------------------------------------------
  // RC oscillator edge detect, one-cycle enable
  // ----------------------------------------------------------------
  logic rc_q;
  logic rc_tick;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) rc_q <= 1'b0;
    else rc_q <= fast_internal_rc_osc;
  end

  assign rc_tick = fast_internal_rc_osc && !rc_q;

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  rpo_phase_e                phase_q;
  rpo_phase_e                phase_d;
  logic [`RPO_CNT_WIDTH-1:0] cnt_q;
  logic                      hold_done_q;
  logic                      ph3_done_q;

  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      RPO_POWERUP: if (power_up_done) phase_d = RPO_PHASE1;
      RPO_PHASE1:  if (phase1_done) phase_d = RPO_PHASE2;
      RPO_PHASE2:  if (phase2_done) phase_d = RPO_PHASE3;
      // Leave only after count and option load both complete
      RPO_PHASE3:  if (ph3_done_q && hold_done_q && opt_if.load_done) begin
        phase_d = RPO_RUN; // [RULE_07] [RULE_14]
      end
      RPO_RUN:     phase_d = RPO_RUN;
      default:     phase_d = RPO_POWERUP;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) phase_q <= RPO_POWERUP;
    else phase_q <= phase_d;
  end

  // Counts RC cycles from the end of phase two
  always_ff @(posedge ref_clk) begin
    if (!reset_n || phase_q != RPO_PHASE3) begin
      cnt_q       <= '0;
      hold_done_q <= 1'b0;
      ph3_done_q  <= 1'b0;
    end else if (rc_tick) begin
      if (cnt_q != '1) cnt_q <= cnt_q + 1'b1;
      if (cnt_q == HOLD_LAST) hold_done_q <= 1'b1; // [RULE_06]
      if (cnt_q == PH3_LAST) ph3_done_q <= 1'b1;   // [RULE_07]
    end
  end

  assign opt_if.load_start = (phase_q != RPO_POWERUP); // [RULE_14]

  // ----------------------------------------------------------------
  // Pad configuration, independent of software while in reset
  // ----------------------------------------------------------------
  logic in_reset;
  logic pwr;
  assign in_reset = (phase_d != RPO_RUN);
  assign pwr      = (phase_d == RPO_POWERUP);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      all_pads_hiz              <= 1'b1;
      reset_pad_out             <= 1'b0;
      reset_pad_oe_n            <= 1'b1;
      boot_source_select_pad_pd <= 1'b0;
      pullup_pads_wpu           <= 1'b0;
      pullup_pads_ibe           <= 1'b0;
      trace_data_out_oe_n       <= '1;
      trace_clock_out_oe_n      <= 1'b1;
      debug_event_out_oe_n      <= 1'b1;
      trace_msg_start_end_oe_n  <= 1'b1;
    end else begin
      // Software override only acts once out of reset
      all_pads_hiz   <= in_reset || !sw_pad_override; // [RULE_01] [RULE_03]
      reset_pad_out  <= 1'b0;
      reset_pad_oe_n <= pwr || !in_reset; // [RULE_02] [RULE_06]
      boot_source_select_pad_pd <= !pwr && in_reset;  // [RULE_04]
      pullup_pads_wpu <= !pwr;                         // [RULE_05]
      pullup_pads_ibe <= !pwr;                         // [RULE_05]
      trace_data_out_oe_n      <= {TRACE_W{pwr || !in_reset}}; // [RULE_08]
      trace_clock_out_oe_n     <= pwr || !in_reset;  // [RULE_08]
      debug_event_out_oe_n     <= pwr || !in_reset;  // [RULE_08]
      trace_msg_start_end_oe_n <= pwr || !in_reset;  // [RULE_08]
    end
  end

  // ----------------------------------------------------------------
  // Option decode and status
  // ----------------------------------------------------------------
  rpo_opt_s opt_s;
  // Fields picked by position, struct member order differs
  assign opt_s = rpo_opt_s'{
    supply_level_select: opt_if.opt_word[`RPO_OPT_SUPPLY_BIT],
    osc_high_margin:     opt_if.opt_word[`RPO_OPT_OSCMARG_BIT],
    watchdog_enable:     opt_if.opt_word[`RPO_OPT_WDOG_BIT]
  };

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      supply_level_select <= 1'b1;
      osc_high_margin     <= 1'b1;
      watchdog_enable     <= 1'b1;
      phase               <= RPO_POWERUP;
      core_run            <= 1'b0;
    end else begin
      supply_level_select <= opt_s.supply_level_select; // [RULE_09]
      osc_high_margin     <= opt_s.osc_high_margin;     // [RULE_10]
      watchdog_enable     <= opt_s.watchdog_enable;     // [RULE_11] [RULE_13]
      phase               <= phase_d;
      core_run            <= !in_reset;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  chk_powerup_all_hiz: assert property ( // [RULE_02]
    phase == RPO_POWERUP |-> all_pads_hiz && reset_pad_oe_n
      && (&trace_data_out_oe_n) && trace_clock_out_oe_n
      && debug_event_out_oe_n && trace_msg_start_end_oe_n
      && !boot_source_select_pad_pd && !pullup_pads_wpu)
    else $error("pad driven during power-up");
  chk_reset_fixed: assert property ( // [RULE_01]
    !core_run |-> all_pads_hiz && !reset_pad_out)
    else $error("software altered pads under reset");
  chk_hiz_after_pwr: assert property ( // [RULE_03]
    (phase != RPO_POWERUP && !core_run) |-> all_pads_hiz)
    else $error("pads not tristate after power-up");
  chk_boot_pulldown: assert property ( // [RULE_04]
    (phase != RPO_POWERUP && !core_run) |-> boot_source_select_pad_pd)
    else $error("boot pad pull-down missing");
  chk_pullups_out: assert property ( // [RULE_05]
    core_run |-> pullup_pads_wpu && pullup_pads_ibe)
    else $error("weak pull-ups off after reset");
  chk_reset_pad_low: assert property ( // [RULE_06]
    (phase != RPO_POWERUP && !core_run) |-> !reset_pad_oe_n
      && !reset_pad_out)
    else $error("reset pad not driven low");
  chk_reset_hold: assert property ( // [RULE_06]
    $rose(core_run) |-> $past(reset_pad_oe_n) == 1'b0 && ph3_done_q
      && hold_done_q)
    else $error("reset pad released early");
  chk_ph3_minimum: assert property ( // [RULE_07]
    (phase_q == RPO_PHASE3 && phase_d == RPO_RUN)
      |-> cnt_q >= PH3_LAST + 1'b1)
    else $error("phase three too short");
  chk_trace_out: assert property ( // [RULE_08]
    (phase != RPO_POWERUP && !core_run) |-> !(|trace_data_out_oe_n)
      && !trace_clock_out_oe_n && !debug_event_out_oe_n
      && !trace_msg_start_end_oe_n)
    else $error("trace pads not output during reset");
  chk_wdog_decode: assert property ( // [RULE_11] [RULE_13]
    watchdog_enable == $past(opt_if.opt_word[`RPO_OPT_WDOG_BIT]))
    else $error("watchdog option decoded wrongly");
  chk_opts_loaded: assert property ( // [RULE_14] [RULE_09] [RULE_10]
    $rose(core_run) |-> opt_if.load_done
      && supply_level_select == opt_if.opt_word[`RPO_OPT_SUPPLY_BIT]
      && osc_high_margin == opt_if.opt_word[`RPO_OPT_OSCMARG_BIT]
      && watchdog_enable == opt_if.opt_word[`RPO_OPT_WDOG_BIT])
    else $error("options not loaded before release");

endmodule

// ==== rpo_reset_pads_tb.sv ====
// Self-checking bench for the reset pad sequencer and option decoder
`include "rpo_defs.svh"

module rpo_reset_pads_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rpo_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int CNT = 2;
  logic        ref_clk = 1'b0;
  logic        reset_n, rc, pu_done, p1_done, p2_done, nvm_valid, sw_ovr;
  logic [2:0]  opt_word;
  logic        rst_out, rst_oe_n, boot_pd, wpu, ibe, hiz;
  logic [3:0]  tdo_oe_n;
  logic        tck_oe_n, evt_oe_n, msg_oe_n, supply, osc, wdog, core_run;
  rpo_phase_e  phase;
  logic [31:0] seed = 32'h11FB;
  logic [2:0]  word;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          rises;
  logic [2:0]  exp_q [$];
  logic [2:0]  exp_w;

  always #5 ref_clk = ~ref_clk;

  rpo_reset_pads #(.HOLD_CYC(CNT), .PH3_CYC(CNT), .TRACE_W(4)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .fast_internal_rc_osc(rc),
    .power_up_done(pu_done), .phase1_done(p1_done),
    .phase2_done(p2_done), .nvm_valid(nvm_valid),
    .user_option_word(opt_word), .sw_pad_override(sw_ovr),
    .reset_pad_out(rst_out), .reset_pad_oe_n(rst_oe_n),
    .boot_source_select_pad_pd(boot_pd), .pullup_pads_wpu(wpu),
    .pullup_pads_ibe(ibe), .all_pads_hiz(hiz),
    .trace_data_out_oe_n(tdo_oe_n), .trace_clock_out_oe_n(tck_oe_n),
    .debug_event_out_oe_n(evt_oe_n),
    .trace_msg_start_end_oe_n(msg_oe_n),
    .supply_level_select(supply), .osc_high_margin(osc),
    .watchdog_enable(wdog), .phase(phase), .core_run(core_run));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Pulse one phase-done input, then expect the next phase
  task automatic pulse(input int sel, input rpo_phase_e nxt);
    @(posedge ref_clk);
    case (sel)
      0: pu_done <= 1'b1;
      1: p1_done <= 1'b1;
      default: p2_done <= 1'b1;
    endcase
    @(posedge ref_clk);
    {pu_done, p1_done, p2_done} <= 3'h0;
    @(negedge ref_clk);
    chk(8'(phase), 8'(nxt));
    chk({hiz, rst_out, rst_oe_n, boot_pd, wpu, ibe}, 8'h27);
    chk({tdo_oe_n, tck_oe_n, evt_oe_n, msg_oe_n}, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // One full reset sequence with a given option word
  // ----------------------------------------------------------------
  task automatic run_seq(input logic [2:0] w);
    @(posedge ref_clk);
    {reset_n, pu_done, p1_done, p2_done, nvm_valid, rc} <= 6'h00;
    sw_ovr <= 1'b1;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({hiz, rst_oe_n, boot_pd, wpu, core_run}, 8'h18);
    chk({tdo_oe_n, tck_oe_n, evt_oe_n, msg_oe_n}, 8'h7F);
    chk({supply, osc, wdog}, 8'h07);
    chk(8'(phase), 8'(RPO_POWERUP));
    @(posedge ref_clk);
    reset_n <= 1'b1;
    opt_word <= w;
    nvm_valid <= 1'b1;
    pulse(0, RPO_PHASE1);
    pulse(1, RPO_PHASE2);
    pulse(2, RPO_PHASE3);
    rises = 0;
    for (int k = 0; k < 60 && core_run !== 1'b1; k++) begin
      @(posedge ref_clk) rc <= (k % 4 < 2);
      if (k % 4 == 0) rises++;
      @(negedge ref_clk);
      if (core_run !== 1'b1) chk({rst_oe_n, boot_pd}, 8'h01);
    end
    @(negedge ref_clk);
    exp_w = exp_q.pop_front();
    chk(8'(rises >= CNT && rises <= CNT + 1), 8'h01);
    chk({core_run, rst_oe_n, rst_out}, 8'h06);
    chk(8'(phase), 8'(RPO_RUN));
    chk({wpu, ibe}, 8'h03);
    chk({tdo_oe_n, tck_oe_n, evt_oe_n, msg_oe_n}, 8'h7F);
    chk(8'(supply), 8'(exp_w[`RPO_OPT_SUPPLY_BIT]));
    chk(8'(osc), 8'(exp_w[`RPO_OPT_OSCMARG_BIT]));
    chk(8'(wdog), 8'(exp_w[`RPO_OPT_WDOG_BIT]));
    chk(8'(hiz), 8'h00);
    @(posedge ref_clk) sw_ovr <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(8'(hiz), 8'h01);
    $display("sequence with option word %h done", w);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and timeout
  // ----------------------------------------------------------------
  initial begin
    {reset_n, rc, pu_done, p1_done, p2_done, nvm_valid, sw_ovr} = 7'h00;
    opt_word = 3'h0;
    for (int it = 0; it < 5; it++) begin
      seed = xs(seed);
      word = (it == 0) ? 3'h0 : (it == 1) ? 3'h7 : seed[2:0];
      exp_q.push_back(word);
      run_seq(word);
    end
    complete_run;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      complete_run;
    end
  end
endmodule
